// >>> hw/pdmc_power_down_mask_control.v
/*
  Power-down mask register bank of the master page: six byte registers,
  the mask selection and the combined power-down controls.
  Assumes a serial-interface decoder that presents one-cycle write and
  read strobes with an address, synchronous to i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pdmc_map.vh"

module pdmc_power_down_mask_control #(
  parameter ADDR_W = `PDMC_ADDR_W,
  parameter DATA_W = `PDMC_DATA_W
) (
  input  wire              i_clk,
  input  wire              i_reset,
  input  wire              i_wr_en,
  input  wire              i_rd_en,
  input  wire [ADDR_W-1:0] i_addr,
  input  wire [DATA_W-1:0] i_wr_data,
  input  wire              i_sleep_pin,
  output reg  [DATA_W-1:0] o_rd_data,
  output reg               o_rd_valid,
  output reg  [3:0]        o_converter_off_pair_ab,
  output reg  [3:0]        o_converter_off_pair_cd,
  output reg  [1:0]        o_buffer_off_pair_ab,
  output reg  [1:0]        o_buffer_off_pair_cd,
  output reg               o_global_sleep
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [DATA_W-1:0] mask1_conv_r;
  reg  [DATA_W-1:0] mask1_buf_r;
  reg  [DATA_W-1:0] mask2_conv_r;
  reg  [DATA_W-1:0] mask2_buf_r;
  reg  [DATA_W-1:0] global_ctrl_r;
  reg  [DATA_W-1:0] apply_ctrl_r;

  // ----------------------------------------------------------------
  // Decode and selection nets
  // ----------------------------------------------------------------
  reg  [DATA_W-1:0] rd_data_nxt;
  reg               rd_hit_nxt;
  reg               global_sleep_nxt;
  wire [3:0]        sel_conv_ab;
  wire [3:0]        sel_conv_cd;
  wire [1:0]        sel_buf_ab;
  wire [1:0]        sel_buf_cd;
  wire              ignore_sleep_pin;
  wire              sleep_mask_choice;
  wire              sleep_mask_apply;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign ignore_sleep_pin  = global_ctrl_r[`PDMC_BIT_IGNORE_PIN];
  assign sleep_mask_choice = global_ctrl_r[`PDMC_BIT_MASK_CHOICE];
  assign sleep_mask_apply  = apply_ctrl_r[`PDMC_BIT_MASK_APPLY];

  // ----------------------------------------------------------------
  // Address decode: one hit line per stored register
  // ----------------------------------------------------------------
  // Hit bits from 0 up: mask one conv, mask one buf, mask two conv,
  // mask two buf, global control, apply control
  localparam                    N_REG   = 6;
  localparam [N_REG*ADDR_W-1:0] REG_OFS = {
    `PDMC_OFS_APPLY_CTRL,
    `PDMC_OFS_GLOBAL_CTRL,
    `PDMC_OFS_MASK2_BUF,
    `PDMC_OFS_MASK2_CONV,
    `PDMC_OFS_MASK1_BUF,
    `PDMC_OFS_MASK1_CONV
  };

  wire [N_REG-1:0]  reg_hit;
  wire [N_REG-1:0]  wr_sel;

  genvar g;
  generate
    for (g = 0; g < N_REG; g = g + 1) begin : g_hit
      assign reg_hit[g] = (i_addr == REG_OFS[g*ADDR_W +: ADDR_W]);
      assign wr_sel[g]  = i_wr_en & reg_hit[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Each stored byte keeps only its writable bits
  always @(posedge i_clk) begin
    if (i_reset) begin
      mask1_conv_r  <= `PDMC_RESET_VALUE;
      mask1_buf_r   <= `PDMC_RESET_VALUE;
      mask2_conv_r  <= `PDMC_RESET_VALUE;
      mask2_buf_r   <= `PDMC_RESET_VALUE;
      global_ctrl_r <= `PDMC_RESET_VALUE;
      apply_ctrl_r  <= `PDMC_RESET_VALUE;
    end else begin
      if (wr_sel[0]) begin
        mask1_conv_r <= i_wr_data;
      end
      if (wr_sel[1]) begin
        mask1_buf_r <= i_wr_data & `PDMC_BUF_RW_MASK;
      end
      if (wr_sel[2]) begin
        mask2_conv_r <= i_wr_data;
      end
      if (wr_sel[3]) begin
        mask2_buf_r <= i_wr_data & `PDMC_BUF_RW_MASK;
      end
      if (wr_sel[4]) begin
        // Reserved low bits are not stored
        global_ctrl_r <= i_wr_data & `PDMC_GLOBAL_RW_MASK;
      end
      if (wr_sel[5]) begin
        apply_ctrl_r <= i_wr_data & `PDMC_APPLY_RW_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always @* begin
    rd_hit_nxt  = |reg_hit;
    rd_data_nxt = `PDMC_RESET_VALUE;
    case (i_addr)
      `PDMC_OFS_MASK1_CONV:  rd_data_nxt = mask1_conv_r;
      `PDMC_OFS_MASK1_BUF:   rd_data_nxt = mask1_buf_r;
      `PDMC_OFS_MASK2_CONV:  rd_data_nxt = mask2_conv_r;
      `PDMC_OFS_MASK2_BUF:   rd_data_nxt = mask2_buf_r;
      `PDMC_OFS_GLOBAL_CTRL: rd_data_nxt = global_ctrl_r;
      `PDMC_OFS_APPLY_CTRL:  rd_data_nxt = apply_ctrl_r;
      default:               rd_data_nxt = `PDMC_RESET_VALUE;
    endcase
  end

  // ----------------------------------------------------------------
  // Mask selection
  // ----------------------------------------------------------------
  // Mask outputs follow one cycle after the controlling write
  pdmc_mask_select #(
    .CONV_W (4),
    .BUF_W  (2)
  ) u_select (
    .i_choice     (sleep_mask_choice),
    .i_apply      (sleep_mask_apply),
    .i_m1_conv_ab (mask1_conv_r[`PDMC_CONV_AB_HI:`PDMC_CONV_AB_LO]),
    .i_m1_conv_cd (mask1_conv_r[`PDMC_CONV_CD_HI:`PDMC_CONV_CD_LO]),
    .i_m1_buf_ab  (mask1_buf_r[`PDMC_BUF_AB_HI:`PDMC_BUF_AB_LO]),
    .i_m1_buf_cd  (mask1_buf_r[`PDMC_BUF_CD_HI:`PDMC_BUF_CD_LO]),
    .i_m2_conv_ab (mask2_conv_r[`PDMC_CONV_AB_HI:`PDMC_CONV_AB_LO]),
    .i_m2_conv_cd (mask2_conv_r[`PDMC_CONV_CD_HI:`PDMC_CONV_CD_LO]),
    .i_m2_buf_ab  (mask2_buf_r[`PDMC_BUF_AB_HI:`PDMC_BUF_AB_LO]),
    .i_m2_buf_cd  (mask2_buf_r[`PDMC_BUF_CD_HI:`PDMC_BUF_CD_LO]),
    .o_conv_ab    (sel_conv_ab),
    .o_conv_cd    (sel_conv_cd),
    .o_buf_ab     (sel_buf_ab),
    .o_buf_cd     (sel_buf_cd)
  );

  // ----------------------------------------------------------------
  // Global power-down: pin unless overridden, else the software bit
  // ----------------------------------------------------------------
  always @* begin
    // Software bit acts only while the pin is overridden, so a write of
    // it with the override clear has no effect
    if (ignore_sleep_pin) begin
      global_sleep_nxt = global_ctrl_r[`PDMC_BIT_GLOBAL_SLEEP];
    end else begin
      global_sleep_nxt = i_sleep_pin;
    end
  end

  // ----------------------------------------------------------------
  // Read port: data holds until the next read
  // ----------------------------------------------------------------
  // A read in the cycle of a write to the same byte returns the old value
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_rd_data  <= `PDMC_RESET_VALUE;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_hit_nxt ? rd_data_nxt : `PDMC_RESET_VALUE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-down outputs
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_converter_off_pair_ab <= 4'h0;
      o_converter_off_pair_cd <= 4'h0;
      o_buffer_off_pair_ab    <= 2'h0;
      o_buffer_off_pair_cd    <= 2'h0;
      o_global_sleep          <= 1'b0;
    end else begin
      o_converter_off_pair_ab <= sel_conv_ab;
      o_converter_off_pair_cd <= sel_conv_cd;
      o_buffer_off_pair_ab    <= sel_buf_ab;
      o_buffer_off_pair_cd    <= sel_buf_cd;
      o_global_sleep          <= global_sleep_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> hw/pdmc_map.vh
/*
  Register offsets, field positions and reset values of the power-down
  mask control bank. Included by the register bank module; definitions only.
*/
`ifndef PDMC_MAP_VH
`define PDMC_MAP_VH

`define PDMC_ADDR_W           8
`define PDMC_DATA_W           8

`define PDMC_OFS_MASK1_CONV   8'h20
`define PDMC_OFS_MASK1_BUF    8'h21
`define PDMC_OFS_MASK2_CONV   8'h23
`define PDMC_OFS_MASK2_BUF    8'h24
`define PDMC_OFS_GLOBAL_CTRL  8'h26
`define PDMC_OFS_APPLY_CTRL   8'h55

`define PDMC_CONV_AB_HI       7
`define PDMC_CONV_AB_LO       4
`define PDMC_CONV_CD_HI       3
`define PDMC_CONV_CD_LO       0
`define PDMC_BUF_CD_HI        7
`define PDMC_BUF_CD_LO        6
`define PDMC_BUF_AB_HI        5
`define PDMC_BUF_AB_LO        4

`define PDMC_BIT_GLOBAL_SLEEP 7
`define PDMC_BIT_IGNORE_PIN   6
`define PDMC_BIT_MASK_CHOICE  5
`define PDMC_BIT_MASK_APPLY   4

`define PDMC_BUF_RW_MASK      8'hf0
`define PDMC_GLOBAL_RW_MASK   8'he0
`define PDMC_APPLY_RW_MASK    8'h10
`define PDMC_RESET_VALUE      8'h00

`endif

// >>> hw/pdmc_mask_select.v
/*
  Chooses one of the two power-down masks and gates it by the apply bit.
  Assumes all inputs are register outputs in the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module pdmc_mask_select #(
  parameter CONV_W = 4,
  parameter BUF_W  = 2
) (
  input  wire              i_choice,
  input  wire              i_apply,
  input  wire [CONV_W-1:0] i_m1_conv_ab,
  input  wire [CONV_W-1:0] i_m1_conv_cd,
  input  wire [BUF_W-1:0]  i_m1_buf_ab,
  input  wire [BUF_W-1:0]  i_m1_buf_cd,
  input  wire [CONV_W-1:0] i_m2_conv_ab,
  input  wire [CONV_W-1:0] i_m2_conv_cd,
  input  wire [BUF_W-1:0]  i_m2_buf_ab,
  input  wire [BUF_W-1:0]  i_m2_buf_cd,
  output wire [CONV_W-1:0] o_conv_ab,
  output wire [CONV_W-1:0] o_conv_cd,
  output wire [BUF_W-1:0]  o_buf_ab,
  output wire [BUF_W-1:0]  o_buf_cd
);

  // Only the chosen mask passes, and only while applied
  assign o_conv_ab = {CONV_W{i_apply}} & (i_choice ? i_m2_conv_ab : i_m1_conv_ab);
  assign o_conv_cd = {CONV_W{i_apply}} & (i_choice ? i_m2_conv_cd : i_m1_conv_cd);
  assign o_buf_ab  = {BUF_W{i_apply}} & (i_choice ? i_m2_buf_ab : i_m1_buf_ab);
  assign o_buf_cd  = {BUF_W{i_apply}} & (i_choice ? i_m2_buf_cd : i_m1_buf_cd);

endmodule

`default_nettype wire

// >>> testbench/pdmc_chk.sv
/* Port checker for the power-down mask bank.
   Assumes it is bound onto the bank and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module pdmc_chk (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_sleep_pin,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic [3:0] o_converter_off_pair_ab,
  input wire logic [3:0] o_converter_off_pair_cd,
  input wire logic [1:0] o_buffer_off_pair_ab,
  input wire logic [1:0] o_buffer_off_pair_cd,
  input wire logic       o_global_sleep
);
  // ----------------------------------------
  // Shadow of written bytes
  // ----------------------------------------
  logic [7:0]  sh_r [0:255];
  logic [11:0] outs;
  assign outs = {o_converter_off_pair_ab, o_converter_off_pair_cd,
                 o_buffer_off_pair_cd, o_buffer_off_pair_ab};
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int k = 0; k < 256; k++) sh_r[k] <= 8'h00;
    end else if (i_wr_en) begin
      sh_r[i_addr] <= i_wr_data;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  mask_one_a: assert property (sh_r[8'h55][4] && !sh_r[8'h26][5] |=>
    outs == {$past(sh_r[8'h20]), $past(sh_r[8'h21][7:4])}) else $error("mask one wrong");
  mask_two_a: assert property (sh_r[8'h55][4] && sh_r[8'h26][5] |=>
    outs == {$past(sh_r[8'h23]), $past(sh_r[8'h24][7:4])}) else $error("mask two wrong");
  apply_off_a: assert property (!sh_r[8'h55][4] |=> outs == 12'h000)
    else $error("mask active while off");
  pin_follow_a: assert property (!sh_r[8'h26][6] |=>
    o_global_sleep == $past(i_sleep_pin)) else $error("pin not followed");
  sleep_cmd_a: assert property (sh_r[8'h26][6] |=>
    o_global_sleep == $past(sh_r[8'h26][7])) else $error("global sleep wrong");
  rd_ctrl_a: assert property (i_rd_en && i_addr == 8'h26 |=> o_rd_valid &&
    o_rd_data == ($past(sh_r[8'h26]) & 8'he0)) else $error("control read wrong");
  rd_buf_a: assert property (i_rd_en && i_addr == 8'h21 |=> o_rd_valid &&
    o_rd_data == ($past(sh_r[8'h21]) & 8'hf0)) else $error("buffer read wrong");
  rd_apply_a: assert property (i_rd_en && i_addr == 8'h55 |=> o_rd_valid &&
    o_rd_data == ($past(sh_r[8'h55]) & 8'h10)) else $error("apply read wrong");
  cover property (sh_r[8'h55][4] && sh_r[8'h26][5]);
  cover property (sh_r[8'h26][6] && o_global_sleep);
  cover property (o_rd_valid);
endmodule
bind pdmc_power_down_mask_control pdmc_chk chk (.i_clk, .i_reset, .i_wr_en, .i_rd_en,
  .i_addr, .i_wr_data, .i_sleep_pin, .o_rd_data, .o_rd_valid, .o_converter_off_pair_ab,
  .o_converter_off_pair_cd, .o_buffer_off_pair_ab, .o_buffer_off_pair_cd, .o_global_sleep);
`default_nettype wire

// >>> testbench/pdmc_host.sv
/* Host model driving byte writes and reads on the strobe bus.
   Assumes the bank samples on the rising edge of i_clk. */
`timescale 1ns/10ps
`default_nettype none
module pdmc_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output var  logic       o_wr_en,
  output var  logic       o_rd_en,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wr_data
);
  // ----------------------------------------
  // Bus cycles, released lines show garbage
  // ----------------------------------------
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'hff;
    o_wr_data = 8'hff;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr = ~a;
    q = {i_rd_valid, i_rd_data};
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_power_down_mask_control.sv
/* Testbench for the power-down mask bank, driven through the host model.
   Assumes the checker binds itself onto the bank. */
`timescale 1ns/10ps
`default_nettype none
module tb_power_down_mask_control;
  logic       i_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_sleep_pin = 1'b0;
  logic       i_wr_en, i_rd_en, o_rd_valid, o_global_sleep;
  logic [7:0] i_addr, i_wr_data, o_rd_data;
  logic [3:0] o_converter_off_pair_ab, o_converter_off_pair_cd;
  logic [1:0] o_buffer_off_pair_ab, o_buffer_off_pair_cd;
  logic [8:0] q;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  always #5 i_clk = ~i_clk;
  pdmc_host host (.i_clk, .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid), .o_wr_en(i_wr_en),
    .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wr_data(i_wr_data));
  pdmc_power_down_mask_control dut (.i_clk, .i_reset, .i_wr_en, .i_rd_en, .i_addr,
    .i_wr_data, .i_sleep_pin, .o_rd_data, .o_rd_valid, .o_converter_off_pair_ab,
    .o_converter_off_pair_cd, .o_buffer_off_pair_ab, .o_buffer_off_pair_cd, .o_global_sleep);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (2) @(negedge i_clk);
  endtask
  task automatic mask_is(input logic [11:0] exp);
    settle();
    chk({o_converter_off_pair_ab, o_converter_off_pair_cd, o_buffer_off_pair_cd,
         o_buffer_off_pair_ab}, exp);
  endtask
  task automatic sleep_is(input logic pin, input logic exp);
    i_sleep_pin = pin;
    settle();
    chk({11'h0, o_global_sleep}, {11'h0, exp});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_access();
    logic [7:0] ta [7] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h55, 8'h26, 8'h30};
    logic [7:0] td [7] = '{8'ha5, 8'h9f, 8'h3c, 8'h6f, 8'hff, 8'h1f, 8'hff};
    logic [7:0] te [7] = '{8'ha5, 8'h90, 8'h3c, 8'h60, 8'h10, 8'h00, 8'h00};
    foreach (ta[k]) begin
      host.rd(ta[k], q);
      chk({3'h0, q}, 12'h100);
      host.wr(ta[k], td[k]);
      host.rd(ta[k], q);
      chk({3'h0, q}, {4'h1, te[k]});
    end
  endtask
  task automatic t_masks();
    mask_is(12'ha59);
    host.wr(8'h26, 8'h20);
    mask_is(12'h3c6);
    host.wr(8'h55, 8'h00);
    mask_is(12'h000);
  endtask
  task automatic t_sleep();
    sleep_is(1'b1, 1'b1);
    host.wr(8'h26, 8'h40);
    sleep_is(1'b1, 1'b0);
    host.wr(8'h26, 8'hc0);
    sleep_is(1'b0, 1'b1);
    host.wr(8'h26, 8'h00);
    sleep_is(1'b0, 1'b0);
  endtask
  task automatic t_reset();
    host.wr(8'h55, 8'h10);
    mask_is(12'ha59);
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    mask_is(12'h000);
    host.rd(8'h55, q);
    chk({3'h0, q}, 12'h100);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_reset = 1'b0;
    t_access();
    t_masks();
    t_sleep();
    t_reset();
    complete_run();
  end
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
